// File: core/isolated_input_port_filter_irq.sv
/*
 * Sixteen isolated inputs: live level, per-channel glitch filters,
 * rising-edge flags with request line, and a port-change detector.
 * Assumes a host port doing full-word accesses and an outside interrupt
 * controller that samples the two request levels.
 */
// Summary of operation
// - Host accesses every register as one full 32-bit word only.
// - Reading the level register gives one bit per input channel.
// - Channel bit reads 1 for high input; upper sixteen bits read zero.
// - Each channel filter accepts a new level only after it persisted.
// - Filter width sets persistence in microseconds, 0 to 65535.
// - After reset all filters are zero, inputs pass straight through.
// - A rising edge sets that channel's bit in the edge flag register.
// - Edge request is high while any enabled edge flag is set.
// - Disabled channels still set flags but do not raise the request.
// - All edge enable bits are cleared by reset.
// - Writing one to an edge clear bit clears the flag; clear self-returns.
// - Another interrupt needs every active flag cleared back to zero.
// - Select mask picks which channels take part in change detection.
// - A selected input change sets its change flag, and the request while change enable is set.
// - Writing a change clear bit clears the flag and re-arms request.
`timescale 1ns/100ps
module isolated_input_port_filter_irq
	import isolated_input_pkg::*;
#(
	parameter int N = NUM_CHANNELS
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// Isolated inputs
	input  wire logic [N-1:0]      input_channel,
	// Host register port
	input  wire bus_req_t          bus_req,
	output logic [DATA_W-1:0]      bus_rdata,
	output logic                   bus_rvalid,
	// Requests to the interrupt controller
	output logic                   rise_irq,
	output logic                   change_irq
);

	typedef struct packed {
		logic [N-1:0]             sync1;
		logic [N-1:0]             sync2;
		logic [PRESCALE_W-1:0]    prescale;
		logic                     tick;
		logic [N-1:0]             filt_prev;
		logic [N-1:0][FILT_W-1:0] width;
		logic [N-1:0]             rise_flag;
		logic [N-1:0]             rise_en;
		logic [N-1:0]             chg_flag;
		logic                     chg_en;
		logic [N-1:0]             chg_mask;
		logic [DATA_W-1:0]        rdata;
		logic                     rvalid;
		logic                     rise_irq;
		logic                     chg_irq;
	} top_state_t;

	top_state_t s_reg;
	top_state_t s_next;
	logic [1:0] rst_pipe;
	logic       rst_sync_b;
	logic [N-1:0] filt;

	// Reset release is synchronised so all state leaves reset on one edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_pipe <= 2'b00;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_pipe[1];

	// Word-aligned filter register hit
	function automatic logic filt_hit(input logic [ADDR_W-1:0] a);
		filt_hit = (a >= OFS_FILT_BASE) && (a <= OFS_FILT_LAST) && (a[1:0] == 2'b00);
	endfunction

	function automatic logic [3:0] filt_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - OFS_FILT_BASE;
		filt_idx = d[5:2];
	endfunction

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_filt
			input_glitch_filter #(
				.W          (FILT_W)
			) u_filt (
				.clk        (clk),
				.rst_sync_b (rst_sync_b),
				.tick_us    (s_reg.tick),
				.width      (s_reg.width[g]),
				.sample     (s_reg.sync2[g]),
				.level      (filt[g])
			);
		end
	endgenerate

	always_comb begin
		logic [N-1:0] rise_set;
		logic [N-1:0] chg_set;
		logic [N-1:0] rise_clr;
		logic [N-1:0] chg_clr;
		rise_set = '0;
		chg_set  = '0;
		rise_clr = '0;
		chg_clr  = '0;
		s_next   = s_reg;

		// Only sync2 reads sync1
		s_next.sync1 = input_channel;
		s_next.sync2 = s_reg.sync1;

		// Microsecond timebase
		if (s_reg.prescale == PRESCALE_W'(TIMEBASE_CYCLES - 1)) begin
			s_next.prescale = '0;
			s_next.tick     = 1'b1;
		end else begin
			s_next.prescale = s_reg.prescale + 7'h01;
			s_next.tick     = 1'b0;
		end

		// Detection on filtered levels
		s_next.filt_prev = filt;
		rise_set = filt & ~s_reg.filt_prev;
		chg_set  = (filt ^ s_reg.filt_prev) & s_reg.chg_mask;

		// Full-word writes; clear registers hold nothing so they read back zero
		if (bus_req.wr) begin
			if (filt_hit(bus_req.addr)) begin
				s_next.width[filt_idx(bus_req.addr)] = bus_req.wdata[FILT_W-1:0];
			end
			case (bus_req.addr)
				OFS_RISE_EN: begin
					s_next.rise_en = bus_req.wdata[N-1:0];
				end
				OFS_RISE_CLR: begin
					rise_clr = bus_req.wdata[N-1:0];
				end
				OFS_CHG_EN: begin
					s_next.chg_en = bus_req.wdata[0];
				end
				OFS_CHG_MASK: begin
					s_next.chg_mask = bus_req.wdata[N-1:0];
				end
				OFS_CHG_CLR: begin
					chg_clr = bus_req.wdata[N-1:0];
				end
				default: begin
				end
			endcase
		end

		// Set wins over a clear in the same cycle so no event is lost
		s_next.rise_flag = (s_reg.rise_flag & ~rise_clr) | rise_set;
		s_next.chg_flag  = (s_reg.chg_flag & ~chg_clr) | chg_set;

		// Levels stay high until every enabled flag is cleared
		s_next.rise_irq = |(s_next.rise_flag & s_next.rise_en);
		s_next.chg_irq  = s_next.chg_en & (|s_next.chg_flag);

		// Reads answer one cycle later; unmapped addresses read zero
		s_next.rvalid = bus_req.rd;
		s_next.rdata  = '0;
		if (bus_req.rd) begin
			if (filt_hit(bus_req.addr)) begin
				s_next.rdata = {16'h0000, s_reg.width[filt_idx(bus_req.addr)]};
			end
			case (bus_req.addr)
				OFS_INPUT_LEVEL: begin
					s_next.rdata = {16'h0000, filt};
				end
				OFS_RISE_FLAG: begin
					s_next.rdata = {16'h0000, s_reg.rise_flag};
				end
				OFS_RISE_EN: begin
					s_next.rdata = {16'h0000, s_reg.rise_en};
				end
				OFS_CHG_FLAG: begin
					s_next.rdata = {16'h0000, s_reg.chg_flag};
				end
				OFS_CHG_EN: begin
					s_next.rdata = {31'h0, s_reg.chg_en};
				end
				OFS_CHG_MASK: begin
					s_next.rdata = {16'h0000, s_reg.chg_mask};
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_reg          <= '0;
			s_reg.width    <= {N{RST_FILT_WIDTH}};
			s_reg.rise_en  <= RST_CHAN_VEC;
			s_reg.chg_en   <= RST_CHG_EN;
			s_reg.chg_mask <= RST_CHAN_VEC;
		end else begin
			s_reg <= s_next;
		end
	end

	assign bus_rdata  = s_reg.rdata;
	assign bus_rvalid = s_reg.rvalid;
	assign rise_irq   = s_reg.rise_irq;
	assign change_irq = s_reg.chg_irq;

endmodule

// File: core/isolated_input_pkg.sv
/*
 * Shared constants and carrier types for the isolated input port block:
 * register byte offsets, field widths, reset values and the timebase.
 * Assumes a byte-addressed host port with full 32-bit accesses only.
 */
package isolated_input_pkg;

	localparam int          NUM_CHANNELS     = 16;
	localparam int          ADDR_W           = 16;
	localparam int          DATA_W           = 32;
	localparam int          FILT_W           = 16;

	// Byte offsets
	localparam logic [15:0] OFS_INPUT_LEVEL  = 16'h0000;
	localparam logic [15:0] OFS_FILT_BASE    = 16'h00a0;
	localparam logic [15:0] OFS_FILT_LAST    = 16'h00dc;
	localparam logic [15:0] OFS_RISE_FLAG    = 16'h0100;
	localparam logic [15:0] OFS_RISE_EN      = 16'h0104;
	localparam logic [15:0] OFS_RISE_CLR     = 16'h0108;
	localparam logic [15:0] OFS_CHG_FLAG     = 16'h0110;
	localparam logic [15:0] OFS_CHG_EN       = 16'h0114;
	localparam logic [15:0] OFS_CHG_MASK     = 16'h0118;
	localparam logic [15:0] OFS_CHG_CLR      = 16'h011c;

	// Reset values
	localparam logic [15:0] RST_FILT_WIDTH   = 16'h0000;
	localparam logic [15:0] RST_CHAN_VEC     = 16'h0000;
	localparam logic        RST_CHG_EN       = 1'b0;

	// Timebase
	localparam int          CLK_PERIOD_NS    = 10;
	localparam int          TIMEBASE_NS      = 1000;
	localparam int          TIMEBASE_CYCLES  = (TIMEBASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int          PRESCALE_W       = 7;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} bus_req_t;

	typedef struct packed {
		logic              level;
		logic [FILT_W-1:0] count;
	} filt_state_t;

endpackage

// File: core/input_glitch_filter.sv
/*
 * One channel of the persistence filter: a new level is taken only after
 * it has stood for the programmed number of microsecond ticks.
 * Assumes a synchronised sample and a one-cycle tick every microsecond.
 */
`timescale 1ns/100ps
module input_glitch_filter
	import isolated_input_pkg::*;
#(
	parameter int W = FILT_W
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_sync_b,
	// Timebase and configuration
	input  wire logic         tick_us,
	input  wire logic [W-1:0] width,
	// Data
	input  wire logic         sample,
	output logic              level
);

	filt_state_t s_reg;
	filt_state_t s_next;

	always_comb begin
		s_next = s_reg;
		if (sample == s_reg.level) begin
			s_next.count = '0;
		end else if (width == '0) begin
			s_next.level = sample;
			s_next.count = '0;
		end else if (tick_us) begin
			// Tick phase is free-running; the first tick only counts as partial, so
			// persistence is at least width us and at most one tick longer
			if (s_reg.count >= width) begin
				s_next.level = sample;
				s_next.count = '0;
			end else begin
				s_next.count = s_reg.count + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign level = s_reg.level;

endmodule

// File: test/input_source_model.sv
/* Far-side model: the isolated input sources.
   Assumes the bench sets the wanted levels. */
`timescale 1ns/100ps
module input_source_model
	import isolated_input_pkg::*;
(
	// Levels
	input wire logic [NUM_CHANNELS-1:0]	level_cmd,
	output logic [NUM_CHANNELS-1:0]		input_channel
);
	// Off the clock grid, so the synchroniser sees truly async edges
	initial begin
		input_channel = '0;
		forever @(level_cmd) input_channel <= #3.3 level_cmd;
	end
endmodule

// File: test/isolated_input_checker.sv
/* Port checker of the isolated input block.
   Assumes a bind to the top module. */
`timescale 1ns/100ps
module isolated_input_checker
	import isolated_input_pkg::*;
#(parameter int N = NUM_CHANNELS) (
	// Watched ports
	input wire logic		clk,
	input wire logic		rst_b,
	input wire logic [N-1:0]	input_channel,
	input wire bus_req_t		bus_req,
	input wire logic [DATA_W-1:0]	bus_rdata,
	input wire logic		bus_rvalid,
	input wire logic		rise_irq,
	input wire logic		change_irq
);
	// Clears judged only after 256 cycles of stable inputs, enough for an edge to leave a zero-width filter
	logic [8:0]	calm_reg;
	logic		rise_w, chg_w;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) calm_reg <= 9'h000;
		else calm_reg <= $stable(input_channel) ? calm_reg + {8'h00, !calm_reg[8]} : 9'h000;
	end
	assign rise_w = bus_req.wr && (bus_req.addr == OFS_RISE_CLR || bus_req.addr == OFS_RISE_EN);
	assign chg_w = bus_req.wr && (bus_req.addr == OFS_CHG_CLR || bus_req.addr == OFS_CHG_EN);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	rd_answer_a: assert property (bus_req.rd |=> bus_rvalid)
		else $error("read unanswered");
	rvalid_pulse_a: assert property (!bus_req.rd |=> !bus_rvalid)
		else $error("stray rvalid");
	high_zero_a: assert property (bus_rvalid |-> bus_rdata[31:16] == 16'h0000)
		else $error("upper bits set");
	reset_quiet_a: assert property ($rose(rst_b) |-> !rise_irq && !change_irq ##1 !rise_irq)
		else $error("request after reset");
	rise_hold_a: assert property (rise_irq && !rise_w && !$past(rise_w) |=> rise_irq)
		else $error("rise request dropped");
	change_hold_a: assert property (change_irq && !chg_w && !$past(chg_w) |=> change_irq)
		else $error("change request dropped");
	rise_clear_a: assert property (rise_w && bus_req.addr == OFS_RISE_CLR && calm_reg[8] &&
		bus_req.wdata[15:0] == 16'hffff |-> ##[1:2] !rise_irq) else $error("rise not cleared");
	change_clear_a: assert property (chg_w && bus_req.addr == OFS_CHG_CLR && calm_reg[8] &&
		bus_req.wdata[15:0] == 16'hffff |-> ##[1:2] !change_irq) else $error("change not cleared");
endmodule

// File: test/tb_isolated_input_port_filter_irq.sv
/* Self-checking bench of the isolated input block.
   Assumes the package offsets and a 100 MHz clock. */
`timescale 1ns/100ps
module tb_isolated_input_port_filter_irq
	import isolated_input_pkg::*;
;
	typedef struct packed {
		logic [15:0]	a;
		logic		w;
		logic [31:0]	d;
		logic [31:0]	e;
	} row_t;
	logic		clk = 1'b0;
	logic		rst_b = 1'b0;
	logic [15:0]	cmd = 16'h0000;
	logic [15:0]	input_channel;
	bus_req_t	req = '0;
	logic [31:0]	rdata;
	logic		rise_irq, change_irq;
	logic		rvalid;
	int		fail_count = 0, n_tests = 0;
	row_t		rows [8] = '{
		'{16'h00a0, 1'b0, 32'h0, 32'h0},
		'{16'h00dc, 1'b1, 32'hffff, 32'hffff},
		'{16'h0104, 1'b1, 32'ha5, 32'ha5},
		'{16'h0114, 1'b1, 32'h1, 32'h1},
		'{16'h0118, 1'b1, 32'h5a5a, 32'h5a5a},
		'{16'h0108, 1'b1, 32'hffffffff, 32'h0},
		'{16'h0200, 1'b1, 32'hffffffff, 32'h0},
		'{16'h0102, 1'b0, 32'h0, 32'h0}};
	input_source_model i_input_source_model (.level_cmd(cmd), .input_channel(input_channel));
	isolated_input_port_filter_irq i_isolated_input_port_filter_irq (.clk(clk), .rst_b(rst_b),
		.input_channel(input_channel), .bus_req(req), .bus_rdata(rdata), .bus_rvalid(rvalid),
		.rise_irq(rise_irq), .change_irq(change_irq));
	initial forever #5 clk = ~clk;
	initial begin
		repeat (3000) @(posedge clk);
		fail_count++;
		$display("Error at %0t: timeout", $time);
		finish_test;
	end
	task automatic check(logic [31:0] got, logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h, want %h", $time, got, exp);
		end
	endtask
	// A read compares its answer with d; a write sends d
	task automatic bus(logic w, logic [15:0] a, logic [31:0] d);
		@(posedge clk);
		#1 req = '{a, d, w, !w};
		@(posedge clk);
		#1 req = '0;
		check({31'h0, rvalid}, {31'h0, !w});
		if (!w) check(rdata, d);
	endtask
	task automatic irq(logic [1:0] e);
		repeat (2) @(posedge clk);
		#1 check({30'h0, rise_irq, change_irq}, {30'h0, e});
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		foreach (rows[i]) begin
			if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
			bus(1'b0, rows[i].a, rows[i].e);
		end
		$display("Done: registers");
		cmd = 16'h4444;
		repeat (8) @(posedge clk);
		bus(1'b0, OFS_INPUT_LEVEL, 32'h4444);
		bus(1'b0, OFS_RISE_FLAG, 32'h4444);
		bus(1'b0, OFS_CHG_FLAG, 32'h4040);
		irq(2'b11);
		bus(1'b1, OFS_RISE_EN, 32'h2);
		irq(2'b01);
		repeat (320) @(posedge clk);
		bus(1'b1, OFS_RISE_CLR, 32'hffffffff);
		bus(1'b1, OFS_CHG_CLR, 32'hffffffff);
		irq(2'b00);
		$display("Done: edges");
		cmd = 16'h4445;
		bus(1'b1, OFS_FILT_BASE + 16'h000c, 32'h2);
		bus(1'b0, OFS_CHG_FLAG, 32'h0);
		// Width 2 accepts after 200 to 300 cycles of a steady level
		cmd[3] = 1'b1;
		repeat (150) @(posedge clk);
		#1 cmd[3] = 1'b0;
		repeat (300) @(posedge clk);
		#1 cmd[3] = 1'b1;
		bus(1'b0, OFS_INPUT_LEVEL, 32'h4445);
		repeat (190) @(posedge clk);
		bus(1'b0, OFS_INPUT_LEVEL, 32'h4445);
		repeat (120) @(posedge clk);
		bus(1'b0, OFS_INPUT_LEVEL, 32'h444d);
		bus(1'b0, OFS_RISE_FLAG, 32'h9);
		irq(2'b01);
		$display("Done: filter");
		// Mid-run reset: requests drop at once, configuration returns to defaults
		rst_b = 1'b0;
		#1 check({30'h0, rise_irq, change_irq}, 32'h0);
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		repeat (3) @(posedge clk);
		bus(1'b0, OFS_RISE_EN, 32'h0);
		bus(1'b0, OFS_CHG_EN, 32'h0);
		bus(1'b0, OFS_CHG_MASK, 32'h0);
		bus(1'b0, OFS_FILT_BASE + 16'h000c, 32'h0);
		bus(1'b0, OFS_RISE_FLAG, 32'h444d);
		irq(2'b00);
		$display("Done: reset");
		finish_test;
	end
endmodule
bind isolated_input_port_filter_irq isolated_input_checker #(.N(N)) i_isolated_input_checker (
	.clk(clk), .rst_b(rst_b), .input_channel(input_channel), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .rise_irq(rise_irq), .change_irq(change_irq));
